// ==== hw/dars_select.v ====
// radio packet address selection, receive filtering and repeater relay
// assumes byte streams with valid/ready/last on serial and radio sides,
// configuration held steady by the surrounding system while traffic flows
`timescale 1ns/10ps
`include "dars_consts.vh"
module dars_select #(
    parameter FIFO_DEPTH = `DARS_FIFO_DEPTH,
    parameter FIFO_AW = `DARS_FIFO_AW
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // configuration
    input wire [`DARS_ADDR_W-1:0] primaryTxAddr,
    input wire [`DARS_ADDR_W-1:0] secondaryTxAddr,
    input wire [`DARS_ADDR_W-1:0] primaryRxAddr,
    input wire [`DARS_ADDR_W-1:0] secondaryRxAddr,
    input wire txAddrEn,
    input wire rxAddrEn,
    input wire repeaterEn,
    input wire autoSwitchEn,
    input wire portSwap,
    input wire supervisionEn,
    // serial port a
    input wire [7:0] aInData,
    input wire aInValid,
    input wire aInLast,
    output wire aInReady,
    output wire [7:0] aOutData,
    output wire aOutValid,
    output wire aOutLast,
    input wire aOutReady,
    // serial port b
    input wire [7:0] bInData,
    input wire bInValid,
    input wire bInLast,
    output wire bInReady,
    output wire [7:0] bOutData,
    output wire bOutValid,
    output wire bOutLast,
    input wire bOutReady,
    // radio receive
    input wire [7:0] radRxData,
    input wire radRxValid,
    input wire radRxLast,
    output wire radRxReady,
    // radio transmit
    output wire [7:0] radTxData,
    output wire radTxValid,
    output wire radTxLast,
    input wire radTxReady,
    // status
    output wire lastMatchSec
);
    localparam R_ADDRH = 3'd0;
    localparam R_ADDRL = 3'd1;
    localparam R_DATA = 3'd2;
    localparam R_DROP = 3'd3;
    localparam R_WAIT = 3'd4;
    localparam T_IDLE = 3'd0;
    localparam T_ADDRH = 3'd1;
    localparam T_ADDRL = 3'd2;
    localparam T_DATA = 3'd3;
    localparam T_MGMT = 3'd4;

    reg rstS1_q, rstS2_q;
    wire rstSyncN = rstS2_q;

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstS1_q <= 1'b0;
            rstS2_q <= 1'b0;
        end
        else
        begin
            rstS1_q <= 1'b1;
            rstS2_q <= rstS1_q;
        end
    end

    // input holding stages keep every ready a flop at half throughput
    reg [8:0] dinH_q, mgH_q, rxH_q;
    reg dinV_q, mgV_q, rxV_q;
    reg dinRdy_q, mgRdy_q, rxRdy_q;
    reg aInRdy_q, bInRdy_q;
    reg [2:0] rState_q, tState_q;
    reg [7:0] rxHi_q;
    reg matchSec_q, relaying_q, lastSec_q;
    reg txSrcRelay_q;
    reg [`DARS_ADDR_W-1:0] txAddr_q;
    reg [7:0] mgCnt_q;
    reg [7:0] txData_q, serData_q;
    reg txValid_q, txLast_q, serLast_q, aOutV_q, bOutV_q;

    // port a is the data port unless swapped
    wire dInValid = portSwap ? bInValid : aInValid;
    wire [8:0] dIn = portSwap ? {bInLast, bInData} : {aInLast, aInData};
    wire mInValid = portSwap ? aInValid : bInValid;
    wire [8:0] mIn = portSwap ? {aInLast, aInData} : {bInLast, bInData};

    wire [8:0] fOut;
    wire fValid, fInReady;
    wire txSlot = !txValid_q || radTxReady;
    wire serSlot = !(aOutV_q || bOutV_q) || (aOutV_q && aOutReady) || (bOutV_q && bOutReady);
    wire [15:0] rxAddr = {rxHi_q, rxH_q[7:0]};
    wire priHit = (rxAddr == primaryRxAddr);
    wire secHit = (rxAddr == secondaryRxAddr);

    wire relayGrant = (tState_q == T_IDLE) && (rState_q == R_WAIT);
    wire relayMove = (tState_q == T_DATA) && txSrcRelay_q && txSlot;
    wire rxDataMove = (rState_q == R_DATA) && rxV_q && serSlot && (!relaying_q || relayMove);
    wire rxEat = rxV_q && ((rState_q == R_ADDRH && rxAddrEn) || rState_q == R_ADDRL ||
                           rState_q == R_DROP || rxDataMove);
    wire serMove = (tState_q == T_DATA) && !txSrcRelay_q && txSlot && fValid;
    wire mgMove = (tState_q == T_MGMT) && txSlot && mgV_q;
    wire mgEat = mgMove || (mgV_q && !supervisionEn);
    wire dataByte = serMove || (relayMove && rxDataMove);
    wire [8:0] dataSel = txSrcRelay_q ? rxH_q : fOut;
    wire mgEnd = mgH_q[8] || (mgCnt_q == `DARS_MGMT_MAX - 8'h01);
    wire goMgmt = supervisionEn && mgV_q;
    wire serialGo = (tState_q == T_IDLE) && !relayGrant && fValid;
    // a serial packet uses the pair of the last match only in auto switch mode
    wire useSec = autoSwitchEn && lastSec_q;

    wire dinV_d = (dinV_q && !fInReady) || (dinRdy_q && dInValid);
    wire mgV_d = (mgV_q && !mgEat) || (mgRdy_q && mInValid);
    wire rxV_d = (rxV_q && !rxEat) || (rxRdy_q && radRxValid);

    always @(posedge ref_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            dinH_q <= 9'h000;
            mgH_q <= 9'h000;
            rxH_q <= 9'h000;
            dinV_q <= 1'b0;
            mgV_q <= 1'b0;
            rxV_q <= 1'b0;
            dinRdy_q <= 1'b0;
            mgRdy_q <= 1'b0;
            rxRdy_q <= 1'b0;
            aInRdy_q <= 1'b0;
            bInRdy_q <= 1'b0;
        end
        else
        begin
            if (dinRdy_q && dInValid)
                dinH_q <= dIn;
            if (mgRdy_q && mInValid)
                mgH_q <= mIn;
            if (rxRdy_q && radRxValid)
                rxH_q <= {radRxLast, radRxData};
            dinV_q <= dinV_d;
            mgV_q <= mgV_d;
            rxV_q <= rxV_d;
            dinRdy_q <= !dinV_d;
            mgRdy_q <= !mgV_d;
            rxRdy_q <= !rxV_d;
            aInRdy_q <= portSwap ? !mgV_d : !dinV_d;
            bInRdy_q <= portSwap ? !dinV_d : !mgV_d;
        end
    end

    // receive side: address check, strip, drop or hand to relay
    always @(posedge ref_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            rState_q <= R_ADDRH;
            rxHi_q <= 8'h00;
            matchSec_q <= `DARS_RST_SEC;
            lastSec_q <= `DARS_RST_SEC;
            relaying_q <= 1'b0;
        end
        else
        begin
            case (rState_q)
                R_ADDRH:
                begin
                    if (rxV_q && rxAddrEn)
                    begin
                        rxHi_q <= rxH_q[7:0];
                        if (!rxH_q[8])
                            rState_q <= R_ADDRL;
                    end
                    else if (rxV_q)
                    begin
                        matchSec_q <= 1'b0;
                        relaying_q <= repeaterEn;
                        rState_q <= repeaterEn ? R_WAIT : R_DATA;
                    end
                end
                R_ADDRL:
                begin
                    if (rxV_q)
                    begin
                        if (rxH_q[8] || !(priHit || secHit))
                            rState_q <= rxH_q[8] ? R_ADDRH : R_DROP;
                        else
                        begin
                            matchSec_q <= !priHit;
                            if (autoSwitchEn)
                                lastSec_q <= !priHit;
                            relaying_q <= repeaterEn;
                            rState_q <= repeaterEn ? R_WAIT : R_DATA;
                        end
                    end
                end
                R_WAIT:
                begin
                    if (relayGrant)
                        rState_q <= R_DATA;
                end
                R_DATA:
                begin
                    if (rxDataMove && rxH_q[8])
                        rState_q <= R_ADDRH;
                end
                R_DROP:
                begin
                    if (rxV_q && rxH_q[8])
                        rState_q <= R_ADDRH;
                end
                default:
                    rState_q <= R_ADDRH;
            endcase
        end
    end

    // transmit side: prepend address, stream data, append management bytes
    always @(posedge ref_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            tState_q <= T_IDLE;
            txSrcRelay_q <= 1'b0;
            txAddr_q <= {`DARS_ADDR_W{1'b0}};
            mgCnt_q <= 8'h00;
            txData_q <= 8'h00;
            txValid_q <= 1'b0;
            txLast_q <= 1'b0;
        end
        else
        begin
            if (txSlot)
                txValid_q <= 1'b0;
            case (tState_q)
                T_IDLE:
                begin
                    if (relayGrant)
                    begin
                        txSrcRelay_q <= 1'b1;
                        // relay only: a secondary match picks the secondary pair
                        txAddr_q <= (repeaterEn && matchSec_q) ? secondaryTxAddr : primaryTxAddr;
                        tState_q <= txAddrEn ? T_ADDRH : T_DATA;
                    end
                    else if (serialGo)
                    begin
                        txSrcRelay_q <= 1'b0;
                        txAddr_q <= useSec ? secondaryTxAddr : primaryTxAddr;
                        tState_q <= txAddrEn ? T_ADDRH : T_DATA;
                    end
                end
                T_ADDRH:
                begin
                    if (txSlot)
                    begin
                        txData_q <= txAddr_q[15:8];
                        txValid_q <= 1'b1;
                        txLast_q <= 1'b0;
                        tState_q <= T_ADDRL;
                    end
                end
                T_ADDRL:
                begin
                    if (txSlot)
                    begin
                        txData_q <= txAddr_q[7:0];
                        txValid_q <= 1'b1;
                        txLast_q <= 1'b0;
                        tState_q <= T_DATA;
                    end
                end
                T_DATA:
                begin
                    if (dataByte)
                    begin
                        txData_q <= dataSel[7:0];
                        txValid_q <= 1'b1;
                        txLast_q <= dataSel[8] && !goMgmt;
                        mgCnt_q <= 8'h00;
                        if (dataSel[8])
                            tState_q <= goMgmt ? T_MGMT : T_IDLE;
                    end
                end
                T_MGMT:
                begin
                    // waits on the management port; a stalled manager stalls the air
                    if (mgMove)
                    begin
                        txData_q <= mgH_q[7:0];
                        txValid_q <= 1'b1;
                        txLast_q <= mgEnd;
                        mgCnt_q <= mgCnt_q + 8'h01;
                        if (mgEnd)
                            tState_q <= T_IDLE;
                    end
                end
                default:
                    tState_q <= T_IDLE;
            endcase
        end
    end

    // received data goes to the data port only; management stays off it
    always @(posedge ref_clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            serData_q <= 8'h00;
            serLast_q <= 1'b0;
            aOutV_q <= 1'b0;
            bOutV_q <= 1'b0;
        end
        else if (serSlot)
        begin
            aOutV_q <= rxDataMove && !portSwap;
            bOutV_q <= rxDataMove && portSwap;
            if (rxDataMove)
            begin
                serData_q <= rxH_q[7:0];
                serLast_q <= rxH_q[8];
            end
        end
    end

    dars_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk(ref_clk),
        .rstSyncN(rstSyncN),
        .inData(dinH_q),
        .inValid(dinV_q),
        .inReady(fInReady),
        .outData(fOut),
        .outValid(fValid),
        .outReady(serMove)
    );

    assign aInReady = aInRdy_q;
    assign bInReady = bInRdy_q;
    assign radRxReady = rxRdy_q;
    assign aOutData = serData_q;
    assign bOutData = serData_q;
    assign aOutLast = serLast_q;
    assign bOutLast = serLast_q;
    assign aOutValid = aOutV_q;
    assign bOutValid = bOutV_q;
    assign radTxData = txData_q;
    assign radTxValid = txValid_q;
    assign radTxLast = txLast_q;
    assign lastMatchSec = lastSec_q;
endmodule

// ==== hw/dars_consts.vh ====
// constants for the dual address repeater select block
// assumes nothing; included by the select block and the bench
`ifndef DARS_CONSTS_VH
`define DARS_CONSTS_VH

// address width and management append limit
`define DARS_ADDR_W 16
`define DARS_MGMT_MAX 8'h3c

// buffered serial data path
`define DARS_FIFO_DEPTH 8
`define DARS_FIFO_AW 3

// reset values of the steering state
`define DARS_RST_SEC 1'b0

`endif

// ==== hw/dars_fifo.v ====
// synchronous byte fifo with valid/ready on both sides
// assumes one clock and an already synchronised active-low reset
`timescale 1ns/10ps
module dars_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire clk,
    input wire rstSyncN,
    // fill side
    input wire [WIDTH-1:0] inData,
    input wire inValid,
    output wire inReady,
    // drain side
    output wire [WIDTH-1:0] outData,
    output wire outValid,
    input wire outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_q;
    reg [AW-1:0] rdPtr_q;
    reg [AW:0] count_q;
    wire doWr;
    wire doRd;

    assign inReady = (count_q != DEPTH[AW:0]);
    assign outValid = (count_q != {(AW+1){1'b0}});
    assign outData = mem[rdPtr_q];
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;

    // storage has no reset; only pointers and count need a defined value
    always @(posedge clk)
    begin
        if (doWr)
            mem[wrPtr_q] <= inData;
    end

    always @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            wrPtr_q <= {AW{1'b0}};
            rdPtr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (doWr)
                wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
            if (doRd)
                rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
            if (doWr && !doRd)
                count_q <= count_q + 1'b1;
            else if (doRd && !doWr)
                count_q <= count_q - 1'b1;
        end
    end
endmodule

// ==== test/dars_select_chk.sv ====
// port-level checks on the address select block
// assumes it is bound into every dars_select instance
`timescale 1ns/10ps
module dars_select_chk #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // configuration
    input wire [15:0] primaryTxAddr,
    input wire [15:0] secondaryTxAddr,
    input wire txAddrEn,
    input wire repeaterEn,
    input wire autoSwitchEn,
    input wire portSwap,
    // streams
    input wire bOutValid,
    input wire aOutValid,
    input wire [7:0] radTxData,
    input wire radTxValid,
    input wire radTxLast,
    input wire radTxReady,
    // status
    input wire lastMatchSec
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    wire txTake = radTxValid && radTxReady;
    reg [1:0] idx_q;
    // byte position in the air packet, saturating once past the address
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            idx_q <= 2'h0;
        else if (txTake)
            idx_q <= radTxLast ? 2'h0 : (idx_q == 2'h2 ? 2'h2 : idx_q + 2'h1);
    end
    property p_tx_hold;
        radTxValid && !radTxReady |=> radTxValid && $stable(radTxData) && $stable(radTxLast);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("air byte moved before taken");
    property p_port_a;
        !portSwap |-> !bOutValid;
    endproperty
    a_port_a: assert property (p_port_a) else $error("data left on management port");
    property p_port_b;
        portSwap |-> !aOutValid;
    endproperty
    a_port_b: assert property (p_port_b) else $error("data left on port a when swapped");
    property p_first;
        txTake && idx_q == 2'h0 && txAddrEn && !repeaterEn && !autoSwitchEn
            |-> radTxData == primaryTxAddr[15:8];
    endproperty
    a_first: assert property (p_first) else $error("serial packet high address wrong");
    property p_second;
        txTake && idx_q == 2'h1 && txAddrEn && !repeaterEn && !autoSwitchEn
            |-> radTxData == primaryTxAddr[7:0];
    endproperty
    a_second: assert property (p_second) else $error("serial packet low address wrong");
    property p_auto;
        txTake && idx_q == 2'h0 && txAddrEn && !repeaterEn && autoSwitchEn
            |-> radTxData == (lastMatchSec ? secondaryTxAddr[15:8] : primaryTxAddr[15:8]);
    endproperty
    a_auto: assert property (p_auto) else $error("auto switch address wrong");
    property p_match_hold;
        $past(!autoSwitchEn) |-> $stable(lastMatchSec);
    endproperty
    a_match_hold: assert property (p_match_hold) else $error("match moved with switch off");
    property p_rst_quiet;
        $rose(rst_n) |-> !radTxValid && !lastMatchSec ##1 !radTxValid && !lastMatchSec;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("not quiet after reset");
endmodule
bind dars_select dars_select_chk #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) chk (.*);

// ==== test/dars_peer.sv ====
// far side model: the air link and the terminals taking serial output
// assumes the bench steers stalls with slow and hold
`timescale 1ns/10ps
module dars_peer (
    // clock
    input wire ref_clk,
    // stall control
    input wire slow,
    input wire hold,
    // readies towards the block
    output reg radTxReady = 1'b0,
    output reg aOutReady = 1'b0,
    output reg bOutReady = 1'b0
);
    reg [2:0] phase_q = 3'h0;
    always @(posedge ref_clk)
    begin
        phase_q <= phase_q + 3'h1;
        // a busy channel takes one byte in four, a held one none at all
        radTxReady <= !hold && (!slow || phase_q[1:0] == 2'h0);
        aOutReady <= !slow || phase_q[0];
        bOutReady <= !slow || phase_q[1];
    end
endmodule

// ==== test/dars_select_bench.sv ====
// self-checking bench with a queue model of the air and serial streams
// assumes the peer model owns the sink readies; inputs move on the rising edge
`timescale 1ns/10ps
`include "dars_consts.vh"
module dars_select_bench;
    reg ref_clk = 1'b0;
    reg rst_n = 1'b0;
    // this hop hears on its neighbour's transmit address
    reg [15:0] primaryTxAddr = 16'h12a4;
    reg [15:0] secondaryTxAddr = 16'h5b3c;
    reg [15:0] primaryRxAddr = 16'h7e01;
    reg [15:0] secondaryRxAddr = 16'hc0d9;
    reg [15:0] missAddr = 16'h0bad;
    reg txAddrEn = 1'b1;
    reg rxAddrEn = 1'b1;
    reg repeaterEn = 1'b0;
    reg autoSwitchEn = 1'b0;
    reg portSwap = 1'b0;
    reg supervisionEn = 1'b0;
    reg slow = 1'b0;
    reg hold = 1'b0;
    reg [2:0][7:0] inData = 24'h0;
    reg [2:0] inValid = 3'h0;
    reg [2:0] inLast = 3'h0;
    wire [2:0] inReady;
    wire [7:0] aOutData, bOutData, radTxData;
    wire aOutValid, aOutLast, bOutValid, bOutLast, radTxValid, radTxLast;
    wire radTxReady, aOutReady, bOutReady, lastMatchSec;
    reg [8:0] txQ[$], expTx[$];
    reg [9:0] outQ[$], expOut[$];
    reg [7:0] mq[$];
    reg [31:0] seed = 32'hdd99b6bf;
    integer errors = 0, checked = 0, aTaken = 0, aBase = 0;
    dars_select DUT (.*, .aInData(inData[0]), .aInValid(inValid[0]), .aInLast(inLast[0]),
        .aInReady(inReady[0]), .bInData(inData[1]), .bInValid(inValid[1]),
        .bInLast(inLast[1]), .bInReady(inReady[1]), .radRxData(inData[2]),
        .radRxValid(inValid[2]), .radRxLast(inLast[2]), .radRxReady(inReady[2]));
    dars_peer peer (.*);
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        if (radTxValid && radTxReady)
            txQ.push_back({radTxLast, radTxData});
        if (aOutValid && aOutReady)
            outQ.push_back({1'b0, aOutLast, aOutData});
        if (bOutValid && bOutReady)
            outQ.push_back({1'b1, bOutLast, bOutData});
        if (inValid[0] && inReady[0])
            aTaken++;
    end
    function [7:0] rnd;
    begin
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        rnd = seed[7:0];
    end
    endfunction
    task check(input [9:0] seen, input [9:0] want);
    begin
        checked++;
        if (seen !== want)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    end
    endtask
    task automatic sendPkt(input integer p, input reg [7:0] b[$]);
        integer k, w;
    begin
        for (k = 0; k < b.size(); k++)
        begin
            inData[p] <= b[k];
            inLast[p] <= k == b.size() - 1;
            inValid[p] <= 1'b1;
            w = 0;
            do
            begin
                @(posedge ref_clk);
                w++;
            end
            while (inReady[p] !== 1'b1 && w < 2000);
            if (w >= 2000)
                check(10'h0, 10'h1);
        end
        // a released line shows the inverse, never a stale copy
        inData[p] <= ~b[b.size() - 1];
        inValid[p] <= 1'b0;
        @(posedge ref_clk);
    end
    endtask
    task automatic txPkt(input integer p, input [15:0] a, input integer n, input lastOn);
        reg [7:0] b[$];
        integer k;
    begin
        if (txAddrEn)
        begin
            expTx.push_back({1'b0, a[15:8]});
            expTx.push_back({1'b0, a[7:0]});
        end
        for (k = 0; k < n; k++)
        begin
            b.push_back(rnd());
            expTx.push_back({lastOn && k == n - 1, b[k]});
        end
        sendPkt(p, b);
    end
    endtask
    task automatic rxPkt(input [15:0] a, input integer n, input take, input relay,
        input [15:0] t);
        reg [7:0] b[$];
        integer k;
    begin
        b = {a[15:8], a[7:0]};
        for (k = 0; k < n; k++)
            b.push_back(rnd());
        if (relay)
            expTx.push_back({1'b0, t[15:8]});
        if (relay)
            expTx.push_back({1'b0, t[7:0]});
        for (k = rxAddrEn ? 2 : 0; k < n + 2; k++)
        begin
            if (take)
                expOut.push_back({portSwap, k == n + 1, b[k]});
            if (relay)
                expTx.push_back({k == n + 1, b[k]});
        end
        sendPkt(2, b);
    end
    endtask
    task automatic drain(input string name);
        integer w;
    begin
        w = 0;
        while ((txQ.size() < expTx.size() || outQ.size() < expOut.size()) && w < 3000)
        begin
            @(posedge ref_clk);
            w++;
        end
        repeat (60) @(posedge ref_clk);
        check(txQ.size(), expTx.size());
        check(outQ.size(), expOut.size());
        while (txQ.size() && expTx.size())
            check(txQ.pop_front(), expTx.pop_front());
        while (outQ.size() && expOut.size())
            check(outQ.pop_front(), expOut.pop_front());
        txQ.delete();
        expTx.delete();
        outQ.delete();
        expOut.delete();
        $display("test %s done, mismatches so far %0d", name, errors);
    end
    endtask
    task give_verdict;
    begin
        $display("comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    initial
    begin
        #400000;
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict;
    end
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        // messages stay far below a kilobyte
        for (int n = 1; n < 9; n++)
            txPkt(0, primaryTxAddr, n, 1'b1);
        mq = {rnd()};
        sendPkt(1, mq);
        drain("serial");
        rxPkt(primaryRxAddr, 3, 1'b1, 1'b0, 16'h0);
        rxPkt(secondaryRxAddr, 4, 1'b1, 1'b0, 16'h0);
        rxPkt(missAddr, 5, 1'b0, 1'b0, 16'h0);
        rxPkt(primaryRxAddr, 0, 1'b0, 1'b0, 16'h0);
        drain("receive");
        rxAddrEn <= 1'b0;
        // let the new setting land before the model reads it
        @(posedge ref_clk);
        rxPkt(missAddr, 3, 1'b1, 1'b0, 16'h0);
        drain("open receive");
        rxAddrEn <= 1'b1;
        portSwap <= 1'b1;
        txPkt(1, primaryTxAddr, 5, 1'b1);
        sendPkt(0, mq);
        rxPkt(primaryRxAddr, 2, 1'b1, 1'b0, 16'h0);
        drain("swap");
        portSwap <= 1'b0;
        // auto switch kept apart from relaying
        autoSwitchEn <= 1'b1;
        @(posedge ref_clk);
        check(lastMatchSec, 1'b0);
        txPkt(0, primaryTxAddr, 3, 1'b1);
        rxPkt(secondaryRxAddr, 2, 1'b1, 1'b0, 16'h0);
        drain("auto fresh");
        check(lastMatchSec, 1'b1);
        txPkt(0, secondaryTxAddr, 3, 1'b1);
        rxPkt(primaryRxAddr, 2, 1'b1, 1'b0, 16'h0);
        drain("auto secondary");
        check(lastMatchSec, 1'b0);
        txPkt(0, primaryTxAddr, 2, 1'b1);
        drain("auto primary");
        autoSwitchEn <= 1'b0;
        slow <= 1'b1;
        repeaterEn <= 1'b1;
        rxPkt(secondaryRxAddr, 4, 1'b1, 1'b1, secondaryTxAddr);
        rxPkt(primaryRxAddr, 3, 1'b1, 1'b1, primaryTxAddr);
        rxPkt(missAddr, 3, 1'b0, 1'b0, 16'h0);
        // the local terminal speaks only once the relay has gone out
        drain("relay");
        txPkt(0, primaryTxAddr, 2, 1'b1);
        drain("relay serial");
        repeaterEn <= 1'b0;
        slow <= 1'b0;
        supervisionEn <= 1'b1;
        mq = {rnd()};
        sendPkt(1, mq);
        txPkt(0, primaryTxAddr, 3, 1'b0);
        expTx.push_back({1'b1, mq[0]});
        drain("supervision");
        supervisionEn <= 1'b0;
        // bare packets go out with no address in front
        txAddrEn <= 1'b0;
        @(posedge ref_clk);
        txPkt(0, primaryTxAddr, 3, 1'b1);
        drain("bare");
        txAddrEn <= 1'b1;
        @(posedge ref_clk);
        hold <= 1'b1;
        aBase = aTaken;
        fork
            txPkt(0, primaryTxAddr, 20, 1'b1);
            begin
                repeat (200) @(posedge ref_clk);
                check(inReady[0], 1'b0);
                check(aTaken - aBase >= `DARS_FIFO_DEPTH, 1'b1);
                hold <= 1'b0;
            end
        join
        drain("buffer");
        give_verdict;
    end
endmodule
